// [logic/sense_seq_pkg.sv]
/*
  Shared constants for the current and temperature sense sequencer:
  register offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package sense_seq_pkg;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_OVR_CLR = 8'h0C;
  localparam logic [7:0] REG_OFFSET = 8'h10;
  localparam logic [7:0] REG_CUR0 = 8'h14;
  localparam logic [7:0] REG_CUR1 = 8'h18;
  localparam logic [7:0] REG_TEMP0 = 8'h1C;
  localparam logic [7:0] REG_TEMP1 = 8'h20;
  localparam logic [7:0] REG_TEMP2 = 8'h24;
  localparam logic [7:0] REG_OUTSEQ = 8'h28;
  // Control fields: bits 1:0 mode, bit 2 start of a command conversion,
  // bits 4:3 current channel for command conversion.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_BIT = 2;
  localparam int CTRL_CH_LSB = 3;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_CMD = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  // Status bits: 0,1 current done; 2..4 temp done; 5,6 overrange.
  localparam int ST_CUR_LSB = 0;
  localparam int ST_TEMP_LSB = 2;
  localparam int ST_OVR_LSB = 5;
  localparam int ST_WIDTH = 7;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // Timing.
  localparam int CLK_MHZ = 100;
  localparam int CHOP_TOTAL_US = 6;
  localparam int CHOP_TOTAL_CYC = CHOP_TOTAL_US * CLK_MHZ;
  localparam int CONV_CYC_DEF = CHOP_TOTAL_CYC / 2 - 2;
  localparam int TEMP_PERIOD_MS = 5;
  localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int TEMP_CHANNELS = 3;
  localparam int INTEG_CYC_DEF = TEMP_PERIOD_CYC / TEMP_CHANNELS;
  localparam int DATA_W = 12;
endpackage : sense_seq_pkg

// [logic/result_store.sv]
/*
  Small register memory for the five result words (two current, three
  temperature) with a registered read port.
  Assumes one writer and one reader, both on i_clk.
*/
`timescale 1ns/1ps
module result_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 5
) (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Write port.
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read port.
  input wire logic [2:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  // Stores a result word when written.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_ff[k] <= '0;
      end
    end else if (i_ce && i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  // Registered read, out-of-range addresses read as zero.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= (int'(i_raddr) < DEPTH) ? mem_ff[i_raddr] : '0;
    end
  end
endmodule : result_store

// [logic/current_temp_sense_sequencer.sv]
/*
  Digital sequencer for chopped high-side current readings, latched
  overrange comparator outputs and background temperature conversion.
  Assumes a shared converter that accepts a start pulse with an input
  swap select and returns a signed sample with a done pulse; comparator
  inputs are synchronous to i_clk.
*/
// Overview of operation
// RL1: Convert shunt voltage, swap amplifier inputs, convert again, combine both.
// RL2: Whole chopped current reading finishes within 6 microseconds.
// RL3: Overrange output goes high when shunt voltage passes the fixed threshold.
// RL4: Two independent comparators, one per channel, fixed non-programmable threshold.
// RL5: Overrange also trips when sense or supply pin drops below analog supply.
// RL6: Each temperature input yields a fresh reading every 5 ms.
// RL7: Temperature inputs integrate in turn, then request a conversion.
// RL8: Command mode serves a pending temperature request after current conversion.
// RL9: Autocycle mode inserts a pending temperature request between sequence steps.
// RL10: Idle converter starts a requested temperature conversion at once.
// RL11: Three temperature result registers, readable at any time.
// RL12: Command mode may return remote temperature results in output sequence.
// RL13: Offset register value is added to each temperature result with sign.
// RL14: Overrange output stays latched until software writes the clear register.
// RL15: Offset is signed and in the same LSB scale as the result.
`timescale 1ns/1ps
module current_temp_sense_sequencer
  import sense_seq_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYC_DEF,
  parameter int INTEG_CYC = INTEG_CYC_DEF
) (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Converter.
  output logic o_conv_start,
  output logic o_chop_swap,
  output logic [2:0] o_conv_chan,
  input wire logic i_conv_done,
  input wire logic [sense_seq_pkg::DATA_W-1:0] i_conv_data,
  // Comparators and supply monitors, one bit per current channel.
  input wire logic [1:0] i_shunt_over_thresh,
  input wire logic [1:0] i_sense_below_avdd,
  // Outputs.
  output logic [1:0] o_current_overrange_output,
  output logic o_irq
);
  import sense_seq_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CUR_A = 5'b00010,
    S_CUR_B = 5'b00100,
    S_TEMP = 5'b01000,
    S_WAIT = 5'b10000
  } state_type;

  localparam int CW = 20;
  localparam int IW = 32;

  state_type state_ff;
  logic [1:0] mode_ff;
  logic [1:0] cmd_ch_ff;
  logic cmd_pend_ff;
  logic cur_ch_ff;
  logic auto_ch_ff;
  logic [DATA_W-1:0] offset_ff;
  logic [DATA_W-1:0] first_ff;
  logic [1:0] tch_ff;
  logic [1:0] serve_ch_ff;
  logic [IW-1:0] integ_ff;
  logic [2:0] treq_ff;
  logic [1:0] outseq_ff;
  logic [ST_WIDTH-1:0] status_ff;
  logic [ST_WIDTH-1:0] mask_ff;
  logic [DATA_W-1:0] cur0_ff;
  logic [DATA_W-1:0] cur1_ff;
  logic [CW-1:0] wd_ff;
  logic rd_pend_ff;
  logic [7:0] rd_addr_ff;

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic start_cmd;
  logic [ST_WIDTH-1:0] ev;
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [2:0] mem_raddr;
  logic [DATA_W-1:0] chop_result;
  logic temp_pending;
  logic [1:0] temp_pick;

  // Combines two chopped samples; the signal sign flips, so halving the
  // difference keeps the signal and cancels amplifier offset.
  function automatic logic [DATA_W-1:0] chop_combine(
    input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic [DATA_W:0] d;
    d = {a[DATA_W-1], a} - {b[DATA_W-1], b};
    return d[DATA_W:1];
  endfunction : chop_combine

  // Saturating signed add of the temperature offset.
  function automatic logic [DATA_W-1:0] add_offset(
    input logic [DATA_W-1:0] t, input logic [DATA_W-1:0] o);
    logic [DATA_W:0] s;
    s = {t[DATA_W-1], t} + {o[DATA_W-1], o};
    if (s[DATA_W] != s[DATA_W-1]) begin
      return s[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}}
                       : {1'b0, {(DATA_W-1){1'b1}}};
    end
    return s[DATA_W-1:0];
  endfunction : add_offset

  // Picks the lowest-numbered pending temperature channel.
  function automatic logic [1:0] first_req(input logic [2:0] r);
    return r[0] ? 2'd0 : (r[1] ? 2'd1 : 2'd2);
  endfunction : first_req

  assign apb_acc = i_psel && i_penable && o_pready;
  assign apb_wr = apb_acc && i_pwrite;
  assign apb_rd = i_psel && !i_penable && !i_pwrite;
  assign start_cmd = apb_wr && (i_paddr == REG_CTRL) &&
                     i_pwdata[CTRL_START_BIT];
  assign chop_result = chop_combine(first_ff, i_conv_data);
  assign temp_pending = |treq_ff;
  assign temp_pick = first_req(treq_ff);

  // Result memory write: temperatures with offset applied.
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = 3'd0;
    mem_wdata = chop_result;
    if (i_conv_done && state_ff == S_TEMP) begin
      mem_we = 1'b1;
      mem_waddr = 3'(serve_ch_ff) + 3'd2;
      mem_wdata = add_offset(i_conv_data, offset_ff); // [RL13] [RL15]
    end else if (i_conv_done && state_ff == S_CUR_B) begin
      mem_we = 1'b1;
      mem_waddr = {2'b00, cur_ch_ff};
    end
  end

  // Read address selects the temperature word for the pending read. The
  // setup-phase address is used directly so the registered memory word is
  // already in place when the access phase answers.
  always_comb begin
    case (apb_rd ? i_paddr : rd_addr_ff)
      REG_TEMP0: mem_raddr = 3'd2; // [RL11]
      REG_TEMP1: mem_raddr = 3'd3;
      REG_TEMP2: mem_raddr = 3'd4;
      REG_OUTSEQ: mem_raddr = outseq_ff[0] ? 3'd3 : 3'd4; // [RL12]
      default: mem_raddr = 3'd7;
    endcase
  end

  result_store #(.WIDTH(DATA_W), .DEPTH(5)) u_store (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // Control registers written by software.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mode_ff <= MODE_IDLE;
      cmd_ch_ff <= 2'd0;
      offset_ff <= '0;
      mask_ff <= '0;
      outseq_ff <= 2'd0;
    end else if (i_ce && apb_wr) begin
      case (i_paddr)
        REG_CTRL: begin
          mode_ff <= i_pwdata[CTRL_MODE_LSB +: 2];
          cmd_ch_ff <= i_pwdata[CTRL_CH_LSB +: 2];
        end
        REG_MASK: mask_ff <= i_pwdata[ST_WIDTH-1:0];
        REG_OFFSET: offset_ff <= i_pwdata[DATA_W-1:0]; // [RL15]
        REG_OUTSEQ: outseq_ff <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Background integration: one channel at a time, each period a
  // third of 5 ms so every channel refreshes once per 5 ms.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      integ_ff <= '0;
      tch_ff <= 2'd0;
    end else if (i_ce) begin
      if (integ_ff == IW'(INTEG_CYC - 1)) begin
        integ_ff <= '0;
        tch_ff <= (tch_ff == 2'd2) ? 2'd0 : tch_ff + 2'd1; // [RL6] [RL7]
      end else begin
        integ_ff <= integ_ff + IW'(1);
      end
    end
  end

  // Conversion requests raised at integration end, cleared when served.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      treq_ff <= 3'd0;
    end else if (i_ce) begin
      for (int k = 0; k < 3; k++) begin
        if (integ_ff == IW'(INTEG_CYC - 1) && tch_ff == 2'(k)) begin
          treq_ff[k] <= 1'b1; // [RL7]
        end else if (state_ff == S_TEMP && o_conv_start &&
                     serve_ch_ff == 2'(k)) begin
          treq_ff[k] <= 1'b0;
        end
      end
    end
  end

  // Command start is held pending until the converter takes it.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmd_pend_ff <= 1'b0;
    end else if (i_ce) begin
      if (start_cmd) begin
        cmd_pend_ff <= 1'b1;
      end else if (state_ff == S_CUR_A && o_conv_start) begin
        cmd_pend_ff <= 1'b0;
      end
    end
  end

  // Converter sequencer: temperature requests go first once the
  // converter is free, which gives idle, command and autocycle service.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_ff <= S_IDLE;
      o_conv_start <= 1'b0;
      o_chop_swap <= 1'b0;
      o_conv_chan <= 3'd0;
      cur_ch_ff <= 1'b0;
      auto_ch_ff <= 1'b0;
      serve_ch_ff <= 2'd0;
      first_ff <= '0;
    end else if (i_ce) begin
      o_conv_start <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (temp_pending) begin
            state_ff <= S_TEMP; // [RL8] [RL9] [RL10]
            serve_ch_ff <= temp_pick;
            o_conv_chan <= 3'(temp_pick) + 3'd2;
            o_chop_swap <= 1'b0;
            o_conv_start <= 1'b1;
          end else if ((mode_ff == MODE_CMD && cmd_pend_ff) ||
                       mode_ff == MODE_AUTO) begin
            state_ff <= S_CUR_A;
            cur_ch_ff <= (mode_ff == MODE_AUTO) ? auto_ch_ff : cmd_ch_ff[0];
            o_conv_chan <= (mode_ff == MODE_AUTO) ? {2'b00, auto_ch_ff}
                                                  : {2'b00, cmd_ch_ff[0]};
            o_chop_swap <= 1'b0; // [RL1]
            o_conv_start <= 1'b1;
          end
        end
        S_CUR_A: begin
          if (i_conv_done) begin
            first_ff <= i_conv_data;
            o_chop_swap <= 1'b1; // [RL1]
            o_conv_start <= 1'b1;
            state_ff <= S_CUR_B;
          end
        end
        S_CUR_B: begin
          if (i_conv_done) begin
            o_chop_swap <= 1'b0;
            auto_ch_ff <= ~cur_ch_ff;
            state_ff <= S_IDLE; // [RL1]
          end
        end
        S_TEMP: begin
          if (i_conv_done) begin
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Counts the cycles of a chopped reading for the total time check. [RL2]
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wd_ff <= '0;
    end else if (i_ce) begin
      if (state_ff == S_CUR_A || state_ff == S_CUR_B) begin
        wd_ff <= wd_ff + CW'(1);
      end else begin
        wd_ff <= '0;
      end
    end
  end

  // Latched overrange outputs; a set in the clear cycle wins.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_current_overrange_output <= 2'b00;
    end else if (i_ce) begin
      for (int k = 0; k < 2; k++) begin
        if (i_shunt_over_thresh[k] || i_sense_below_avdd[k]) begin
          o_current_overrange_output[k] <= 1'b1; // [RL3] [RL4] [RL5]
        end else if (apb_wr && i_paddr == REG_OVR_CLR && i_pwdata[k]) begin
          o_current_overrange_output[k] <= 1'b0; // [RL14]
        end
      end
    end
  end

  // Event sources for the sticky status register.
  always_comb begin
    ev = '0;
    ev[ST_CUR_LSB] = mem_we && state_ff == S_CUR_B && !cur_ch_ff;
    ev[ST_CUR_LSB+1] = mem_we && state_ff == S_CUR_B && cur_ch_ff;
    for (int k = 0; k < 3; k++) begin
      ev[ST_TEMP_LSB+k] = mem_we && state_ff == S_TEMP &&
                          serve_ch_ff == 2'(k);
    end
    ev[ST_OVR_LSB +: 2] = i_shunt_over_thresh | i_sense_below_avdd;
  end

  // Sticky status, write one to clear, set wins.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status_ff <= '0;
      cur0_ff <= '0;
      cur1_ff <= '0;
    end else if (i_ce) begin
      if (apb_wr && i_paddr == REG_STATUS) begin
        status_ff <= (status_ff & ~i_pwdata[ST_WIDTH-1:0]) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
      if (ev[ST_CUR_LSB]) cur0_ff <= chop_result;
      if (ev[ST_CUR_LSB+1]) cur1_ff <= chop_result;
    end
  end

  // Interrupt output.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(status_ff & mask_ff);
    end
  end

  // APB: writes and reads both answer in the second access cycle; reads use the memory word fetched at setup.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= RESET_VALUE;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 8'h00;
    end else if (i_ce) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      rd_pend_ff <= apb_rd;
      if (apb_rd) rd_addr_ff <= i_paddr;
      if (i_psel && i_penable && !o_pready && (i_pwrite || rd_pend_ff)) begin
        o_pready <= 1'b1;
        o_pslverr <= (i_paddr > REG_OUTSEQ) || (i_paddr[1:0] != 2'b00);
        o_prdata <= RESET_VALUE;
        if (!i_pwrite) begin
          case (rd_addr_ff)
            REG_CTRL: o_prdata <= {27'd0, cmd_ch_ff, cmd_pend_ff, mode_ff};
            REG_STATUS: o_prdata <= {25'd0, status_ff};
            REG_MASK: o_prdata <= {25'd0, mask_ff};
            REG_OVR_CLR: o_prdata <= {30'd0, o_current_overrange_output};
            REG_OFFSET: o_prdata <= {20'd0, offset_ff};
            REG_CUR0: o_prdata <= {20'd0, cur0_ff};
            REG_CUR1: o_prdata <= {20'd0, cur1_ff};
            REG_TEMP0, REG_TEMP1, REG_TEMP2, REG_OUTSEQ:
              o_prdata <= {20'd0, mem_rdata}; // [RL11] [RL12]
            default: o_prdata <= RESET_VALUE;
          endcase
        end
      end
    end
  end

  // First half of a chopped reading has come back.
  sequence first_conv_done_s;
    i_ce && state_ff == S_CUR_A && i_conv_done;
  endsequence

  // A command reading ends while a temperature request waits.
  sequence cmd_conv_end_temp_s;
    i_ce && state_ff == S_CUR_B && i_conv_done && mode_ff == MODE_CMD &&
    temp_pending ##1 i_ce;
  endsequence

  // Assertions.
  AST_CHOP_TIME: assert property ( // [RL2]
    @(posedge i_clk) disable iff (!i_reset_n)
    wd_ff <= CW'(CHOP_TOTAL_CYC))
    else $error("chopped reading exceeded total time");
  AST_SWAP_SECOND: assert property ( // [RL1]
    @(posedge i_clk) disable iff (!i_reset_n)
    first_conv_done_s |=> o_chop_swap && o_conv_start)
    else $error("second conversion not swapped");
  AST_OVR_SET: assert property ( // [RL3]
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && (i_shunt_over_thresh[0] || i_sense_below_avdd[0])
    |=> o_current_overrange_output[0])
    else $error("overrange 0 not set");
  AST_OVR_SUPPLY: assert property ( // [RL5]
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && i_sense_below_avdd[1] |=> o_current_overrange_output[1])
    else $error("overrange 1 not set on low supply");
  AST_OVR_HOLD: assert property ( // [RL14]
    @(posedge i_clk) disable iff (!i_reset_n)
    o_current_overrange_output[0] && !(apb_wr && i_paddr == REG_OVR_CLR)
    |=> o_current_overrange_output[0])
    else $error("overrange released without clear");
  AST_IDLE_TEMP: assert property ( // [RL10]
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && state_ff == S_IDLE && temp_pending
    |=> state_ff == S_TEMP && o_conv_start)
    else $error("idle converter did not start temperature");
  AST_CMD_AFTER: assert property ( // [RL8]
    @(posedge i_clk) disable iff (!i_reset_n)
    cmd_conv_end_temp_s |=> state_ff == S_TEMP)
    else $error("pending temperature not served after conversion");
  AST_TEMP_REQ: assert property ( // [RL7]
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && integ_ff == IW'(INTEG_CYC - 1) && tch_ff == 2'd1
    |=> treq_ff[1])
    else $error("integration end raised no request");
endmodule : current_temp_sense_sequencer

// [test/conv_model.sv]
/*
  Behavioural model of the shared converter with the shunt and the
  temperature sensors behind it.
  Assumes one-cycle start pulses from the sequencer on rising i_clk.
*/
`timescale 1ns/1ps
module conv_model (
  // Clock.
  input wire logic i_clk,
  // Request from the sequencer; latency set by the bench.
  input wire logic i_start,
  input wire logic i_swap,
  input wire logic [2:0] i_chan,
  input wire logic [7:0] i_lat,
  // Answer to the sequencer.
  output logic o_done,
  output logic [11:0] o_data
);
  logic busy_ff;
  logic [7:0] wait_ff;
  logic [11:0] samp_ff;
  logic [11:0] cur;

  // Shunt voltage seen by each current channel.
  assign cur = i_chan[0] ? 12'h0C8 : 12'h064;

  // Power-up state of the model.
  initial begin
    busy_ff = 1'b0;
    wait_ff = 8'h00;
    samp_ff = 12'h000;
    o_done = 1'b0;
    o_data = 12'h000;
  end

  // Answer i_lat+1 cycles after the start; data toggles between answers.
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_start) begin
      busy_ff <= 1'b1;
      wait_ff <= i_lat;
      if (i_chan < 3'h2) begin
        samp_ff <= i_swap ? 12'h010 - cur : 12'h010 + cur;
      end else begin
        samp_ff <= 12'h100 + {9'h000, i_chan};
      end
    end else if (busy_ff) begin
      if (wait_ff == 8'h00) begin
        busy_ff <= 1'b0;
        o_done <= 1'b1;
        o_data <= samp_ff;
      end else begin
        wait_ff <= wait_ff - 8'h01;
      end
    end
  end
endmodule : conv_model

// [test/test_current_temp_sense_sequencer.sv]
/*
  Self-checking bench for the sense sequencer over APB.
  Assumes the converter model in conv_model.sv.
*/
`timescale 1ns/1ps
module test_current_temp_sense_sequencer;
  import sense_seq_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, err, irq;
  logic start, swap, done;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] chan;
  logic [11:0] cdata;
  logic [1:0] over, below, ovr;
  int num_errors, compares;
  int cyc = 0;

  // Integration long enough that no temperature request meets the first
  // chopped readings, so their timing is measured alone.
  current_temp_sense_sequencer #(.INTEG_CYC(1000))
    current_temp_sense_sequencer_inst (
    .i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(err), .o_conv_start(start),
    .o_chop_swap(swap), .o_conv_chan(chan), .i_conv_done(done),
    .i_conv_data(cdata), .i_shunt_over_thresh(over),
    .i_sense_below_avdd(below), .o_current_overrange_output(ovr),
    .o_irq(irq));

  conv_model conv_model_inst (.i_clk(clk), .i_start(start),
    .i_swap(swap), .i_chan(chan), .i_lat(lat), .o_done(done),
    .o_data(cdata));

  // Clock and cycle count.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task conclude;
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // One APB transfer; waits for pready, which should come at the second
  // access edge; only the watchdog ends a wait that never finishes.
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'd2);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task wait_st(input logic [31:0] m, input int lim);
    int n;
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while ((q & m) !== m && n < lim);
    chk(q & m, m);
  endtask : wait_st

  task t_reset;
    rd(REG_CTRL);
    chk(q, RESET_VALUE);
    chk({30'h0, ovr}, 32'h0);
    rd(8'h2C);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    wr(8'h2C, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
  endtask : t_reset

  task t_chop(input logic [1:0] ch, input logic [7:0] l);
    int t0;
    lat <= l;
    wr(REG_MASK, 32'h1 << ch);
    wr(REG_STATUS, 32'h0000_007F);
    t0 = cyc;
    wr(REG_CTRL, {27'h0, ch, 1'b1, MODE_CMD});
    wait_st(32'h1 << ch, 300);
    chk({31'h0, cyc - t0 <= 610}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(ch[0] ? REG_CUR1 : REG_CUR0);
    chk(q, ch[0] ? 32'h0000_00C8 : 32'h0000_0064);
    wr(REG_STATUS, 32'h1 << ch);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_chop

  task t_ovr;
    wr(REG_MASK, 32'h0000_0060);
    over <= 2'b01;
    @(posedge clk);
    over <= 2'b00;
    repeat (3) @(posedge clk);
    chk({30'h0, ovr}, 32'h1);
    below <= 2'b10;
    @(posedge clk);
    below <= 2'b00;
    repeat (3) @(posedge clk);
    chk({30'h0, ovr}, 32'h3);
    chk({31'h0, irq}, 32'h1);
    over <= 2'b01;
    wr(REG_OVR_CLR, 32'h1);
    over <= 2'b00;
    @(posedge clk);
    chk({30'h0, ovr}, 32'h3);
    wr(REG_OVR_CLR, 32'h1);
    @(posedge clk);
    chk({30'h0, ovr}, 32'h2);
    wr(REG_OVR_CLR, 32'h2);
    wr(REG_STATUS, 32'h0000_0060);
    repeat (2) @(posedge clk);
    chk({30'h0, ovr}, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_ovr

  task t_temp;
    int ofs[2];
    ofs[0] = -2;
    ofs[1] = 3;
    lat <= 8'h04;
    wr(REG_CTRL, {30'h0, MODE_IDLE});
    for (int j = 0; j < 2; j++) begin
      wr(REG_OFFSET, ofs[j] & 32'h0000_0FFF);
      wr(REG_STATUS, 32'h0000_001C);
      wait_st(32'h0000_001C, 1000);
      for (int i = 0; i < 3; i++) begin
        rd(REG_TEMP0 + 8'(4 * i));
        chk(q, 32'h102 + i + ofs[j]);
      end
    end
    wr(REG_CTRL, {30'h0, MODE_CMD});
    wr(REG_OUTSEQ, 32'h1);
    rd(REG_OUTSEQ);
    chk(q, 32'h0000_0106);
    wr(REG_OUTSEQ, 32'h0);
    rd(REG_OUTSEQ);
    chk(q, 32'h0000_0107);
  endtask : t_temp

  // A command reading is started so that a temperature request lands in
  // its middle; the temperature must follow once the reading is stored.
  task t_cmd_temp;
    int n;
    n = 0;
    lat <= 8'hFA;
    while (cyc % 1000 != 700) @(posedge clk);
    wr(REG_STATUS, 32'h0000_007F);
    wr(REG_CTRL, {27'h0, 2'd0, 1'b1, MODE_CMD});
    wait_st(32'h0000_0001, 300);
    chk(q & 32'h0000_001C, 32'h0);
    do begin
      rd(REG_STATUS);
      n++;
    end while ((q & 32'h0000_001C) == 32'h0 && n < 100);
    chk({31'h0, (q & 32'h0000_001C) != 32'h0}, 32'h1);
    rd(REG_CUR0);
    chk(q, 32'h0000_0064);
  endtask : t_cmd_temp

  task t_auto;
    lat <= 8'h08;
    wr(REG_STATUS, 32'h0000_007F);
    wr(REG_CTRL, {30'h0, MODE_AUTO});
    wait_st(32'h0000_001F, 1000);
    rd(REG_CUR0);
    chk(q, 32'h0000_0064);
    rd(REG_CUR1);
    chk(q, 32'h0000_00C8);
  endtask : t_auto

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    over = 2'b00;
    below = 2'b00;
    lat = 8'h02;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_chop(2'd0, 8'h02);
    t_chop(2'd1, 8'hFA);
    t_ovr;
    t_temp;
    t_cmd_temp;
    t_auto;
    conclude;
  end

  // Cut a hang short.
  initial begin
    #500000;
    num_errors++;
    conclude;
  end
endmodule : test_current_temp_sense_sequencer
